// [verilog/cpg_pkg.sv]
package cpg_pkg;
	// register byte offsets
	localparam logic [11:0] SYS_CLK_CTL_OFS = 12'h000;
	localparam logic [11:0] LOW_PWR_CTL_OFS = 12'h004;
	localparam logic [11:0] STBY_CTL_OFS = 12'h008;
	localparam logic [11:0] STATUS_OFS = 12'h00C;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;

	// system_clock_control fields
	localparam int SCC_PHI_OFF_BIT = 7;
	localparam int SCC_SWITCH_MODE_BIT = 3;
	localparam int SCC_BUS_SEL_LSB = 0;
	localparam logic [7:0] SCC_WR_MASK = 8'h8F;
	localparam logic [7:0] SCC_RESET = 8'h00;

	// low_power_control fields
	localparam int LPC_FACTOR_LSB = 0;
	localparam logic [7:0] LPC_WR_MASK = 8'h0F;
	localparam logic [7:0] LPC_RESET = 8'h00;

	// standby_control fields
	localparam int SBC_ON_SLEEP_BIT = 7;
	localparam int SBC_WAIT_SEL_LSB = 4;
	localparam logic [7:0] SBC_WR_MASK = 8'hF0;
	localparam logic [7:0] SBC_RESET = 8'h00;

	// status fields
	localparam int STA_FACTOR_LSB = 0;
	localparam int STA_PLL_RUN_BIT = 4;
	localparam int STA_MODE_LSB = 8;

	// mode vector bit positions
	localparam int MODE_HIGH = 0;
	localparam int MODE_MEDIUM = 1;
	localparam int MODE_SLEEP = 2;
	localparam int MODE_MSTOP = 3;
	localparam int MODE_SW_STBY = 4;
	localparam int MODE_HW_STBY = 5;
	localparam int MODE_W = 6;

	localparam logic [1:0] FACTOR_X1 = 2'h0;
	localparam logic [1:0] FACTOR_X2 = 2'h1;
	localparam logic [1:0] FACTOR_X4 = 2'h2;
	localparam int DIV_STAGES = 5;

	// timing: clock period and stabilization wait unit
	localparam int CLK_PERIOD_NS = 4;
	localparam int WAIT_UNIT_NS = 32768;
	localparam int WAIT_UNIT_CYC = (WAIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_SLEEP = 5'h02,
		ST_STBY = 5'h04,
		ST_WAIT = 5'h08,
		ST_HWSTBY = 5'h10
	} cpg_state_e;

	// multiplier value; the prohibited code falls back to x1
	function automatic logic [2:0] cpg_mult(input logic [1:0] f);
		case (f)
			FACTOR_X1: cpg_mult = 3'h1;
			FACTOR_X2: cpg_mult = 3'h2;
			FACTOR_X4: cpg_mult = 3'h4;
			default: cpg_mult = 3'h1;
		endcase
	endfunction

	// 0 = full speed, 1..5 = divide by 2..32; prohibited codes run full speed
	function automatic logic [2:0] cpg_div_index(input logic [2:0] sel);
		cpg_div_index = (sel > 3'h5) ? 3'h0 : sel;
	endfunction
endpackage

// [verilog/cpg_div_if.sv]
`timescale 1ns/10ps
interface cpg_div_if;
	logic run;
	logic [2:0] sel;
	logic [4:0] tick;
	logic bus_en;
	modport ctl (output run, output sel, input tick, input bus_en);
	modport div (input run, input sel, output tick, output bus_en);
endinterface

// [verilog/cpg_div.sv]
`timescale 1ns/10ps
module cpg_div
	import cpg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	cpg_div_if.div dif
);
	logic [DIV_STAGES-1:0] cnt_q;
	logic [DIV_STAGES-1:0] tick_q;
	logic [DIV_STAGES-1:0] tick_d;
	logic bus_en_q;
	logic bus_en_d;
	logic [2:0] idx;

	// tick k marks one cycle in 2^(k+1), a clock enable rather than a gated clock
	genvar k;
	generate
		for (k = 0; k < DIV_STAGES; k++) begin : g_stage
			assign tick_d[k] = dif.run & (&cnt_q[k:0]);
		end
	endgenerate

	assign idx = cpg_div_index(dif.sel);
	assign bus_en_d = dif.run & ((idx == 3'h0) ? 1'b1 : tick_d[idx - 3'h1]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			tick_q <= '0;
			bus_en_q <= 1'b0;
		end else begin
			cnt_q <= dif.run ? cnt_q + 5'h01 : cnt_q;
			tick_q <= tick_d;
			bus_en_q <= bus_en_d;
		end
	end

	assign dif.tick = tick_q;
	assign dif.bus_en = bus_en_q;
endmodule

// [verilog/cpg_top.sv]
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - multiply oscillator clock by 1, 2 or 4 per the factor bits
// - factor is x1 after reset
// - switch mode 0: new factor waits for software standby entry
// - deferred mode: transition time counted per standby wait select
// - deferred mode: standby stops the generator and pending factor becomes active
// - on standby exit wait the programmed time, then run at new factor
// - break on sleep: standby, stabilization wait, then break exception
// - switch mode 1: factor takes effect right after the write
// - divider makes phi/2 through phi/32
// - bus master gets full clock or one of five divided clocks
// - high-speed mode after reset
// - six operating modes; all but high-speed are power-down
// - sleep, medium speed and module stop are separate, combinable states
// - sleep enters sleep when standby-on-sleep is 0, standby when 1
// - interrupt ends sleep or standby, back to high or medium speed
// - factor codes 00 x1, 01 x2, 10 x4; 11 not to be written
// - bus select 000 full, 001..101 divided; 11X not to be written
// - wait select sets stabilization wait when interrupt cancels standby
module cpg_top
	import cpg_pkg::*;
#(
	parameter int unsigned WAIT_UNIT_CYCLES = WAIT_UNIT_CYC
) (
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [cpg_pkg::APB_AW-1:0] PADDR_I,
	input wire logic [cpg_pkg::APB_DW-1:0] PWDATA_I,
	output logic [cpg_pkg::APB_DW-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic SLEEP_EXEC_I,
	input wire logic PROG_BREAK_I,
	input wire logic MODULE_STOP_I,
	input wire logic WAKE_IRQ_I,
	input wire logic HW_STANDBY_I,
	output logic [1:0] ACTIVE_FACTOR_O,
	output logic [2:0] PLL_MULT_O,
	output logic PLL_RUN_O,
	output logic CPU_RUN_O,
	output logic PHI_OUT_EN_O,
	output logic BREAK_EXC_O,
	output logic [cpg_pkg::DIV_STAGES-1:0] MED_TICK_O,
	output logic BUS_CLK_EN_O,
	output logic [cpg_pkg::MODE_W-1:0] MODE_O
);
	import cpg_pkg::*;

	cpg_state_e state_q;
	cpg_state_e state_d;
	logic [7:0] scc_q;
	logic [7:0] lpc_q;
	logic [7:0] sbc_q;
	logic [1:0] active_q;
	logic [1:0] active_d;
	logic [2:0] mult_q;
	logic [31:0] wait_cnt_q;
	logic [31:0] wait_cnt_d;
	logic brk_pend_q;
	logic brk_pend_d;
	logic brk_exc_q;
	logic [APB_DW-1:0] prdata_q;
	logic [1:0] wake_sync_q;
	logic [1:0] hws_sync_q;

	// pins pass two flops; only the second stage is read
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			wake_sync_q <= 2'h0;
			hws_sync_q <= 2'h0;
		end else begin
			wake_sync_q <= {wake_sync_q[0], WAKE_IRQ_I};
			hws_sync_q <= {hws_sync_q[0], HW_STANDBY_I};
		end
	end

	wire wake = wake_sync_q[1];
	wire hw_stby = hws_sync_q[1];

	// register bus decode
	wire apb_setup = PSEL_I & ~PENABLE_I;
	wire apb_access = PSEL_I & PENABLE_I;
	wire hit_scc = (PADDR_I == SYS_CLK_CTL_OFS);
	wire hit_lpc = (PADDR_I == LOW_PWR_CTL_OFS);
	wire hit_sbc = (PADDR_I == STBY_CTL_OFS);
	wire hit_sta = (PADDR_I == STATUS_OFS);
	wire hit_any = hit_scc | hit_lpc | hit_sbc | hit_sta;
	wire wr_scc = apb_access & PWRITE_I & hit_scc;
	wire wr_lpc = apb_access & PWRITE_I & hit_lpc;
	wire wr_sbc = apb_access & PWRITE_I & hit_sbc;

	wire switch_now = scc_q[SCC_SWITCH_MODE_BIT];
	wire [2:0] bus_sel = scc_q[SCC_BUS_SEL_LSB +: 3];
	wire on_sleep_stby = sbc_q[SBC_ON_SLEEP_BIT];
	wire [2:0] wait_sel = sbc_q[SBC_WAIT_SEL_LSB +: 3];
	wire [1:0] pending = lpc_q[LPC_FACTOR_LSB +: 2];
	wire medium_sel = (cpg_div_index(bus_sel) != 3'h0);
	wire [31:0] wait_load = 32'(WAIT_UNIT_CYCLES << wait_sel) - 32'h1;

	wire [MODE_W-1:0] mode_vec;
	assign mode_vec[MODE_HIGH] = (state_q == ST_RUN) & ~medium_sel;
	assign mode_vec[MODE_MEDIUM] = ((state_q == ST_RUN) | (state_q == ST_SLEEP)) & medium_sel;
	assign mode_vec[MODE_SLEEP] = (state_q == ST_SLEEP);
	assign mode_vec[MODE_MSTOP] = MODULE_STOP_I & ((state_q == ST_RUN) | (state_q == ST_SLEEP));
	assign mode_vec[MODE_SW_STBY] = (state_q == ST_STBY) | (state_q == ST_WAIT);
	assign mode_vec[MODE_HW_STBY] = (state_q == ST_HWSTBY);

	wire [APB_DW-1:0] sta_word = {18'h0, mode_vec, 3'h0, (state_q != ST_STBY) &
		(state_q != ST_HWSTBY), 2'h0, active_q};
	wire [APB_DW-1:0] rd_mux = hit_scc ? {24'h0, scc_q} :
		hit_lpc ? {24'h0, lpc_q} :
		hit_sbc ? {24'h0, sbc_q} :
		hit_sta ? sta_word : 32'h0;

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			scc_q <= SCC_RESET;
			lpc_q <= LPC_RESET;
			sbc_q <= SBC_RESET;
			prdata_q <= 32'h0;
		end else begin
			if (wr_scc)
				scc_q <= PWDATA_I[7:0] & SCC_WR_MASK;
			if (wr_lpc)
				lpc_q <= PWDATA_I[7:0] & LPC_WR_MASK;
			if (wr_sbc)
				sbc_q <= PWDATA_I[7:0] & SBC_WR_MASK;
			// read data is latched in the setup phase so it is a flop output
			if (apb_setup)
				prdata_q <= rd_mux;
		end
	end

	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_access & ~hit_any;
	assign PRDATA_O = prdata_q;

	// power-mode sequencer
	wire enter_stby = SLEEP_EXEC_I & (on_sleep_stby | PROG_BREAK_I);
	wire wait_done = (wait_cnt_q == 32'h0);

	always_comb begin
		state_d = state_q;
		wait_cnt_d = wait_cnt_q;
		brk_pend_d = brk_pend_q;
		case (state_q)
			ST_RUN: begin
				if (enter_stby) begin
					state_d = ST_STBY;
					brk_pend_d = PROG_BREAK_I;
				end else if (SLEEP_EXEC_I) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake)
					state_d = ST_RUN;
			end
			ST_STBY: begin
				// a break exits on its own; otherwise an interrupt cancels standby
				if (wake | brk_pend_q) begin
					state_d = ST_WAIT;
					wait_cnt_d = wait_load;
				end
			end
			ST_WAIT: begin
				if (wait_done) begin
					state_d = ST_RUN;
					brk_pend_d = 1'b0;
				end else begin
					wait_cnt_d = wait_cnt_q - 32'h1;
				end
			end
			ST_HWSTBY: begin
				if (!hw_stby) begin
					state_d = ST_WAIT;
					wait_cnt_d = wait_load;
				end
			end
			default: state_d = ST_RUN;
		endcase
		if (hw_stby)
			state_d = ST_HWSTBY;
	end

	// immediate mode follows the write; deferred mode only on standby entry
	assign active_d = (wr_lpc & switch_now) ? PWDATA_I[LPC_FACTOR_LSB +: 2] :
		((state_q == ST_RUN) & enter_stby) ? pending : active_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			state_q <= ST_RUN;
			wait_cnt_q <= 32'h0;
			brk_pend_q <= 1'b0;
			brk_exc_q <= 1'b0;
			active_q <= FACTOR_X1;
			mult_q <= 3'h1;
		end else begin
			state_q <= state_d;
			wait_cnt_q <= wait_cnt_d;
			brk_pend_q <= brk_pend_d;
			brk_exc_q <= (state_q == ST_WAIT) & wait_done & brk_pend_q & ~hw_stby;
			active_q <= active_d;
			mult_q <= cpg_mult(active_d);
		end
	end

	cpg_div_if dif ();
	assign dif.run = (state_q == ST_RUN) | (state_q == ST_SLEEP);
	assign dif.sel = bus_sel;

	cpg_div u_div (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.dif(dif)
	);

	assign ACTIVE_FACTOR_O = active_q;
	assign PLL_MULT_O = mult_q;
	assign PLL_RUN_O = (state_q != ST_STBY) & (state_q != ST_HWSTBY);
	assign CPU_RUN_O = (state_q == ST_RUN);
	assign PHI_OUT_EN_O = ~scc_q[SCC_PHI_OFF_BIT] & ((state_q == ST_RUN) | (state_q == ST_SLEEP));
	assign BREAK_EXC_O = brk_exc_q;
	assign MED_TICK_O = dif.tick;
	assign BUS_CLK_EN_O = dif.bus_en;
	assign MODE_O = mode_vec;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_mult_map;
		mult_q == ((active_q == 2'h1) ? 3'h2 : (active_q == 2'h2) ? 3'h4 : 3'h1);
	endproperty
	a_mult_map: assert property (p_mult_map) else $error("multiplier does not match factor");

	property p_reset_x1;
		$fell(SYS_RST_I) |-> (mult_q == 3'h1) && (state_q == ST_RUN);
	endproperty
	a_reset_x1: assert property (p_reset_x1) else $error("not x1 high-speed after reset");

	property p_deferred_hold;
		(wr_lpc && !switch_now && state_q == ST_RUN && !enter_stby) |=> $stable(active_q);
	endproperty
	a_deferred_hold: assert property (p_deferred_hold) else $error("deferred factor applied early");

	property p_stby_load;
		(state_q == ST_RUN && enter_stby && !hw_stby) |=> (state_q == ST_STBY)
			&& (active_q == $past(pending)) && !PLL_RUN_O;
	endproperty
	a_stby_load: assert property (p_stby_load) else $error("standby entry did not load factor");

	property p_wait_len;
		(state_q == ST_STBY && wake && !hw_stby) |=> (wait_cnt_q == $past(wait_load));
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("stabilization count wrong");

	property p_wait_exit;
		(state_q == ST_WAIT && wait_done && !hw_stby) |=> (state_q == ST_RUN) && CPU_RUN_O;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("no resume after wait");

	property p_immediate;
		(wr_lpc && switch_now) |=> (active_q == $past(PWDATA_I[1:0]));
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate factor not applied");

	property p_sleep_sel;
		(state_q == ST_RUN && SLEEP_EXEC_I && !hw_stby) |=>
			(state_q == ($past(on_sleep_stby | PROG_BREAK_I) ? ST_STBY : ST_SLEEP));
	endproperty
	a_sleep_sel: assert property (p_sleep_sel) else $error("wrong power-down target");

	property p_sleep_wake;
		(state_q == ST_SLEEP && wake && !hw_stby) |=> (state_q == ST_RUN);
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("interrupt did not end sleep");

	property p_break_exc;
		(state_q == ST_WAIT && wait_done && brk_pend_q && !hw_stby) |=> BREAK_EXC_O;
	endproperty
	a_break_exc: assert property (p_break_exc) else $error("break exception missing");

	property p_full_speed;
		(dif.run && cpg_div_index(bus_sel) == 3'h0) ##1 (dif.run && $stable(bus_sel)) |->
			BUS_CLK_EN_O;
	endproperty
	a_full_speed: assert property (p_full_speed) else $error("full speed clock gated");

	c_deferred: cover property ((state_q == ST_STBY) ##1 (state_q == ST_WAIT));
	c_sleep: cover property ((state_q == ST_SLEEP) ##1 (state_q == ST_RUN));
	c_break: cover property (BREAK_EXC_O);
	c_medium: cover property (mode_vec[MODE_MEDIUM] && BUS_CLK_EN_O);
endmodule

// [tb/cpg_osc_model.sv]
`timescale 1ns/10ps
// oscillator input as seen from the far side; a complementary source parks it high in standby
module cpg_osc_model (
	input wire logic clk_i,
	input wire logic run_i,
	output logic osc_in_o
);
	initial osc_in_o = 1'b1;
	always @(posedge clk_i) begin
		osc_in_o <= run_i ? ~osc_in_o : 1'b1;
	end
endmodule

// [tb/cpg_top_bench.sv]
`timescale 1ns/10ps
module cpg_top_bench;
	import cpg_pkg::*;
	logic clk, rst, psel, pen, pwr, slp, brk, mstp, wake, hws;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, pll_run, cpu_run, phi_en, brk_exc, bus_en, osc, e;
	logic [1:0] fac;
	logic [2:0] mult;
	logic [4:0] tick;
	logic [5:0] mode;
	int miscompares = 0;
	int samples_checked = 0;
	int n;

	cpg_top #(.WAIT_UNIT_CYCLES(4)) u_cpg_top (.CORE_CLK_I(clk), .SYS_RST_I(rst),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SLEEP_EXEC_I(slp),
		.PROG_BREAK_I(brk), .MODULE_STOP_I(mstp), .WAKE_IRQ_I(wake), .HW_STANDBY_I(hws),
		.ACTIVE_FACTOR_O(fac), .PLL_MULT_O(mult), .PLL_RUN_O(pll_run), .CPU_RUN_O(cpu_run),
		.PHI_OUT_EN_O(phi_en), .BREAK_EXC_O(brk_exc), .MED_TICK_O(tick),
		.BUS_CLK_EN_O(bus_en), .MODE_O(mode));
	cpg_osc_model u_cpg_osc_model (.clk_i(clk), .run_i(pll_run), .osc_in_o(osc));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask

	task end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// pready is sampled at each edge of the access phase; data taken at that edge only
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// let the edge's register updates settle before the caller looks at outputs
		#1;
	endtask

	task sleep_pulse(input logic b);
		@(posedge clk);
		slp <= 1'b1;
		brk <= b;
		@(posedge clk);
		slp <= 1'b0;
		brk <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// wake and count cycles until the cpu runs again
	task wake_up();
		@(posedge clk);
		wake <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_run !== 1'b1 && n < 200);
		wake <= 1'b0;
		@(posedge clk);
	endtask

	task t_reset();
		chk(fac === FACTOR_X1 && mult === 3'h1, "factor after reset");
		chk(mode === 6'h01 && cpu_run === 1'b1, "mode after reset");
		apb(1'b0, SYS_CLK_CTL_OFS, 32'h0);
		chk(r === 32'h0, "scc reset value");
		apb(1'b0, 12'h010, 32'h0);
		chk(e === 1'b1 && r === 32'h0, "unmapped read");
		$display("test reset done");
	endtask

	task t_immediate();
		apb(1'b1, SYS_CLK_CTL_OFS, 32'h08);
		apb(1'b1, LOW_PWR_CTL_OFS, 32'h01);
		chk(fac === FACTOR_X2 && mult === 3'h2, "x2 immediate");
		apb(1'b1, LOW_PWR_CTL_OFS, 32'h02);
		chk(fac === FACTOR_X4 && mult === 3'h4, "x4 immediate");
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(r === 32'h00000112 && e === 1'b0, "status word");
		$display("test immediate done");
	endtask

	task t_deferred();
		apb(1'b1, SYS_CLK_CTL_OFS, 32'h00);
		apb(1'b1, STBY_CTL_OFS, 32'h90);
		apb(1'b1, LOW_PWR_CTL_OFS, 32'h00);
		chk(mult === 3'h4, "old factor kept");
		sleep_pulse(1'b0);
		chk(mode[MODE_SW_STBY] === 1'b1 && pll_run === 1'b0, "standby entry");
		chk(mult === 3'h1 && fac === FACTOR_X1, "pending factor active");
		chk(osc === 1'b1, "oscillator parked high");
		wake_up();
		chk(n >= 8 && n <= 16, "standby wait length");
		chk(mode === 6'h01 && mult === 3'h1, "back to high speed");
		$display("test deferred done");
	endtask

	task t_sleep();
		apb(1'b1, STBY_CTL_OFS, 32'h00);
		sleep_pulse(1'b0);
		chk(mode[MODE_SLEEP] === 1'b1 && pll_run === 1'b1, "sleep entry");
		chk(cpu_run === 1'b0, "cpu halted in sleep");
		wake_up();
		chk(mode === 6'h01 && n <= 6, "sleep exit");
		$display("test sleep done");
	endtask

	task t_break();
		sleep_pulse(1'b1);
		n = 0;
		while (brk_exc !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(brk_exc === 1'b1 && n >= 4, "break exception after wait");
		@(posedge clk);
		chk(cpu_run === 1'b1 && brk_exc === 1'b0, "break pulse one cycle");
		$display("test break done");
	endtask

	task t_hwstby();
		@(posedge clk);
		mstp <= 1'b1;
		hws <= 1'b1;
		@(posedge clk);
		#1;
		chk(mode === 6'h09, "module stop beside high speed");
		repeat (3) @(posedge clk);
		#1;
		chk(mode === 6'h20 && pll_run === 1'b0 && cpu_run === 1'b0, "hardware standby");
		chk(phi_en === 1'b0, "phi off in hardware standby");
		@(posedge clk);
		hws <= 1'b0;
		mstp <= 1'b0;
		repeat (12) @(posedge clk);
		#1;
		chk(mode === 6'h01 && cpu_run === 1'b1 && phi_en === 1'b1, "hardware standby exit");
		$display("test hardware standby done");
	endtask

	task t_divider();
		// codes 6 and 7 are not to be written; they fall back to full speed
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, SYS_CLK_CTL_OFS, 32'(s));
			repeat (64) @(posedge clk);
			n = 0;
			for (int i = 0; i < 64; i++) begin
				@(posedge clk);
				n += int'(bus_en === 1'b1);
			end
			chk(n == ((s == 0 || s > 5) ? 64 : (64 >> s)), "bus clock enable rate");
			chk(mode[MODE_MEDIUM] === (s >= 1 && s <= 5) && mode[MODE_HIGH] === (s == 0 || s > 5),
				"medium-speed mode flag");
		end
		for (int k = 0; k < 5; k++) begin
			n = 0;
			for (int i = 0; i < 64; i++) begin
				@(posedge clk);
				n += int'(tick[k] === 1'b1);
			end
			chk(n == (64 >> (k + 1)), "divided tick rate");
		end
		apb(1'b1, SYS_CLK_CTL_OFS, 32'h80);
		chk(phi_en === 1'b0 && bus_en === 1'b1, "phi output disabled");
		$display("test divider done");
	endtask

	initial begin
		rst = 1'b1;
		{psel, pen, pwr, slp, brk, mstp, wake, hws} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_immediate();
		t_deferred();
		t_sleep();
		t_break();
		t_hwstby();
		t_divider();
		end_of_test();
	end

	initial begin
		#40000;
		miscompares++;
		end_of_test();
	end
endmodule
